/* File: wdt_pkg.sv */
// shared constants, register map and types of the watchdog timer
package wdt_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_RELOAD_UPPER = 12'h0FF1;
  localparam logic [11:0] IDX_RELOAD_MIDDLE = 12'h0FF2;
  localparam logic [11:0] IDX_RELOAD_LOW = 12'h0FF3;
  localparam logic [11:0] IDX_STATUS = 12'h0FF4;
  localparam logic [11:0] IDX_MASK = 12'h0FF5;
  localparam logic [11:0] IDX_OPTIONS = 12'h0FF6;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int CNT_W = 24;
  localparam int BYTE_W = 8;
  localparam int FLAG_W = 2;

  // reload byte positions inside the 24-bit value
  localparam int UPPER_LSB = 16;
  localparam int MIDDLE_LSB = 8;
  localparam int LOW_LSB = 0;

  // reset values
  localparam logic [BYTE_W-1:0] RST_RELOAD_UPPER = 8'h00;
  localparam logic [BYTE_W-1:0] RST_RELOAD_MIDDLE = 8'h04;
  localparam logic [BYTE_W-1:0] RST_RELOAD_LOW = 8'h00;
  localparam logic [FLAG_W-1:0] RST_MASK = 2'h1;

  // counter thresholds and decrement step
  localparam logic [CNT_W-1:0] TERMINAL_CNT = 24'h00_0001;
  localparam logic [CNT_W-1:0] NO_REFRESH_CNT = 24'h00_0002;
  localparam logic [CNT_W-1:0] CNT_STEP = 24'h00_0001;

  // status / mask field positions
  localparam int FLAG_TIMEOUT_IRQ = 0;
  localparam int FLAG_WDT_RESET = 1;

  // options register field positions
  localparam int OPT_ENABLED = 0;
  localparam int OPT_ALWAYS_ON = 1;
  localparam int OPT_RESPONSE = 2;

  // option encodings
  localparam logic AO_RUN_FROM_RESET = 1'b0;
  localparam logic RESP_SYSTEM_RESET = 1'b1;

  typedef enum {
    SEL_NONE,
    SEL_UPPER,
    SEL_MIDDLE,
    SEL_LOW,
    SEL_STATUS,
    SEL_MASK,
    SEL_OPTIONS
  } reg_sel_t;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
    byte_addr = {2'h0, idx, 2'h0};
  endfunction

  function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] a);
    if (a == byte_addr(IDX_RELOAD_UPPER)) begin
      decode_addr = SEL_UPPER;
    end else if (a == byte_addr(IDX_RELOAD_MIDDLE)) begin
      decode_addr = SEL_MIDDLE;
    end else if (a == byte_addr(IDX_RELOAD_LOW)) begin
      decode_addr = SEL_LOW;
    end else if (a == byte_addr(IDX_STATUS)) begin
      decode_addr = SEL_STATUS;
    end else if (a == byte_addr(IDX_MASK)) begin
      decode_addr = SEL_MASK;
    end else if (a == byte_addr(IDX_OPTIONS)) begin
      decode_addr = SEL_OPTIONS;
    end else begin
      decode_addr = SEL_NONE;
    end
  endfunction
endpackage

/* File: wdt_sync2.sv */
// two-flop synchroniser for a level arriving from outside pclk
`timescale 1ns/1ps
module wdt_sync2 (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level in and out
  input wire logic d,
  output logic q
);
  logic meta_ff;
  logic q_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      q_ff <= 1'b0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule // wdt_sync2

/* File: wdt_down_counter.sv */
// loadable down counter holding the watchdog count
`timescale 1ns/1ps
module wdt_down_counter #(
  parameter int WIDTH = 24,
  parameter logic [WIDTH-1:0] RESET_VAL = '0,
  parameter logic [WIDTH-1:0] STEP = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic dec,
  // state
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;

  if (WIDTH < 2) begin : g_bad_width
    $error("counter width must be at least 2");
  end

  // load beats decrement
  always_comb begin
    nxt_count = count_ff;
    if (load) begin
      nxt_count = load_val;
    end else if (dec) begin
      nxt_count = count_ff - STEP;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= RESET_VAL;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign count = count_ff;
endmodule // wdt_down_counter

/* File: watchdog_timer_24bit.sv */
// watchdog timer: 24-bit down counter, apb registers, reset or irq response
// Functional notes
// R1 - retriggerable one-shot; at terminal count issue reset or interrupt
// R2 - time-out response selectable: system reset or interrupt request
// R3 - counter advances only on edges of its own rc oscillator
// R4 - 24-bit down counter loaded from three byte-wide reload registers
// R5 - reload value is upper, middle, low byte from msb down
// R6 - period in ms equals reload value over ten at 10 kHz
// R7 - only on or off; once on counts until refreshed or expired
// R8 - enabled by refresh instruction or by always-on option
// R9 - with always-on active, counting starts right after reset
// R10 - at count 2 or below refreshes are ignored
// R11 - software never programs a reload value below 4
// R12 - reads return live count bytes; writes update one reload byte
// R13 - response option 1 gives system reset, 0 gives interrupt
// R14 - a watchdog-caused reset sets a status flag for software
// R15 - always-on option 0 runs from power-up, cannot be disabled
// R16 - option 1: refresh-enabled dog stops only on reset or stop recovery
// R17 - refresh while enabled and above threshold reloads the counter
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module watchdog_timer_24bit
  import wdt_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // watchdog oscillator pin
  input wire logic rc_osc_clk,
  // cpu and option inputs
  input wire logic watchdog_refresh,
  input wire logic stop_mode_recovery,
  input wire logic always_on_option,
  input wire logic timeout_response_select,
  // system outputs
  output logic wdt_reset_req,
  output logic irq
);
  logic rc_sync;
  logic rc_prev_ff;
  logic tick;
  logic [CNT_W-1:0] count;
  logic cnt_load;
  logic cnt_dec;
  logic refresh_ok;
  logic expire;

  logic [CNT_W-1:0] reload_ff, nxt_reload;
  logic enabled_ff, nxt_enabled;
  logic strap_done_ff, nxt_strap_done;
  logic ao_ff, nxt_ao;
  logic resp_ff, nxt_resp;
  logic reset_req_ff, nxt_reset_req;
  logic [FLAG_W-1:0] status_ff, nxt_status;
  logic [FLAG_W-1:0] mask_ff, nxt_mask;
  logic [FLAG_W-1:0] flag_set;
  logic [DATA_W-1:0] prdata_ff, nxt_prdata;
  logic pslverr_ff, nxt_pslverr;

  reg_sel_t sel;
  logic setup;
  logic wr;
  logic [BYTE_W-1:0] wbyte;

  // oscillator edges; only the second sync flop is looked at
  wdt_sync2 u_rc_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(rc_osc_clk),
    .q(rc_sync)
  );

  wdt_down_counter #(
    .WIDTH(CNT_W),
    .RESET_VAL({RST_RELOAD_UPPER, RST_RELOAD_MIDDLE, RST_RELOAD_LOW}),
    .STEP(CNT_STEP)
  ) u_counter (
    .clk(pclk),
    .rst_n(presetn),
    .load(cnt_load),
    .load_val(reload_ff),
    .dec(cnt_dec),
    .count(count)
  );

  always_comb begin
    tick = rc_sync & ~rc_prev_ff; // R3
    // refresh ignored while enabled and count is at or below 2
    refresh_ok = watchdog_refresh &
      (~enabled_ff | (count > NO_REFRESH_CNT)); // R10 R17
    expire = enabled_ff & tick & (count <= TERMINAL_CNT); // R1 R7
    cnt_load = refresh_ok | expire; // R17 R1
    cnt_dec = enabled_ff & tick & ~cnt_load; // R4 R6
  end

  // bus decode and byte lane
  always_comb begin
    sel = decode_addr(paddr);
    setup = psel & ~penable;
    wr = psel & penable & pwrite & pstrb[0];
    wbyte = pwdata[BYTE_W-1:0];
  end

  // control and register next values
  always_comb begin
    nxt_strap_done = 1'b1;
    nxt_ao = strap_done_ff ? ao_ff : always_on_option;
    nxt_resp = strap_done_ff ? resp_ff : timeout_response_select;
    nxt_enabled = enabled_ff;
    if (strap_done_ff) begin
      if (ao_ff == AO_RUN_FROM_RESET) begin
        nxt_enabled = 1'b1; // R9 R15
      end else if (watchdog_refresh) begin
        nxt_enabled = 1'b1; // R8
      end else if (stop_mode_recovery) begin
        nxt_enabled = 1'b0; // R16
      end
    end
    nxt_reset_req = expire & (resp_ff == RESP_SYSTEM_RESET); // R2 R13
    flag_set = '0;
    flag_set[FLAG_TIMEOUT_IRQ] = expire &
      (resp_ff != RESP_SYSTEM_RESET); // R2 R13
    flag_set[FLAG_WDT_RESET] = reset_req_ff; // R14
    nxt_reload = reload_ff;
    nxt_mask = mask_ff;
    nxt_status = status_ff;
    if (wr) begin
      unique case (sel)
        SEL_UPPER:
          nxt_reload[UPPER_LSB +: BYTE_W] = wbyte; // R12 R5
        SEL_MIDDLE:
          nxt_reload[MIDDLE_LSB +: BYTE_W] = wbyte; // R12 R5
        SEL_LOW:
          nxt_reload[LOW_LSB +: BYTE_W] = wbyte; // R12 R5
        SEL_STATUS:
          nxt_status = status_ff & ~wbyte[FLAG_W-1:0];
        SEL_MASK:
          nxt_mask = wbyte[FLAG_W-1:0];
        SEL_OPTIONS, SEL_NONE: begin
        end
      endcase
    end
    // a new event beats a same-cycle clear
    nxt_status = nxt_status | flag_set;
  end

  // read data captured in the setup cycle, answered in access
  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_pslverr = pslverr_ff;
    if (setup) begin
      nxt_prdata = '0;
      nxt_pslverr = (sel == SEL_NONE);
      unique case (sel)
        SEL_UPPER:
          nxt_prdata[BYTE_W-1:0] = count[UPPER_LSB +: BYTE_W]; // R12
        SEL_MIDDLE:
          nxt_prdata[BYTE_W-1:0] = count[MIDDLE_LSB +: BYTE_W]; // R12
        SEL_LOW:
          nxt_prdata[BYTE_W-1:0] = count[LOW_LSB +: BYTE_W]; // R12
        SEL_STATUS:
          nxt_prdata[FLAG_W-1:0] = status_ff;
        SEL_MASK:
          nxt_prdata[FLAG_W-1:0] = mask_ff;
        SEL_OPTIONS: begin
          nxt_prdata[OPT_ENABLED] = enabled_ff;
          nxt_prdata[OPT_ALWAYS_ON] = ao_ff;
          nxt_prdata[OPT_RESPONSE] = resp_ff;
        end
        SEL_NONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_prev_ff <= 1'b0;
      strap_done_ff <= 1'b0;
      ao_ff <= 1'b1;
      resp_ff <= RESP_SYSTEM_RESET;
      enabled_ff <= 1'b0;
      reset_req_ff <= 1'b0;
      reload_ff <= {RST_RELOAD_UPPER, RST_RELOAD_MIDDLE, RST_RELOAD_LOW};
      status_ff <= '0;
      mask_ff <= RST_MASK;
      prdata_ff <= '0;
      pslverr_ff <= 1'b0;
    end else begin
      rc_prev_ff <= rc_sync;
      strap_done_ff <= nxt_strap_done;
      ao_ff <= nxt_ao;
      resp_ff <= nxt_resp;
      enabled_ff <= nxt_enabled;
      reset_req_ff <= nxt_reset_req;
      reload_ff <= nxt_reload;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff & psel & penable;
  // zero wait states: data is already registered in setup
  assign pready = 1'b1;
  assign wdt_reset_req = reset_req_ff;
  assign irq = |(status_ff & mask_ff);

  AST_TIMEOUT_RESET: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    (expire && resp_ff) |=> (wdt_reset_req ##1 status_ff[FLAG_WDT_RESET])
  ) else $error("time-out in reset mode did not request reset");

  AST_TIMEOUT_IRQ: assert property ( // R2
    @(posedge pclk) disable iff (!presetn)
    (enabled_ff && tick && count <= TERMINAL_CNT && !resp_ff)
      |=> (status_ff[FLAG_TIMEOUT_IRQ] && !wdt_reset_req)
  ) else $error("time-out in interrupt mode did not flag interrupt");

  AST_COUNT_NEEDS_TICK: assert property ( // R3
    @(posedge pclk) disable iff (!presetn)
    (!tick && !watchdog_refresh) |=> $stable(count)
  ) else $error("count moved without oscillator edge or refresh");

  AST_DEC_BY_ONE: assert property ( // R4
    @(posedge pclk) disable iff (!presetn)
    (enabled_ff && tick && !watchdog_refresh && count > TERMINAL_CNT)
      |=> (count == $past(count) - CNT_STEP)
  ) else $error("count did not step down by one");

  AST_STAYS_ON: assert property ( // R7
    @(posedge pclk) disable iff (!presetn)
    (enabled_ff && !stop_mode_recovery) |=> enabled_ff
  ) else $error("watchdog switched off without recovery");

  AST_ALWAYS_ON: assert property ( // R9
    @(posedge pclk) disable iff (!presetn)
    (strap_done_ff && ao_ff == AO_RUN_FROM_RESET) |=> enabled_ff [*2]
  ) else $error("always-on watchdog not running");

  AST_NO_LATE_REFRESH: assert property ( // R10
    @(posedge pclk) disable iff (!presetn)
    (enabled_ff && watchdog_refresh && !tick && count <= NO_REFRESH_CNT)
      |=> (count == $past(count))
  ) else $error("refresh accepted at or below threshold");

  AST_REFRESH_RELOADS: assert property ( // R17
    @(posedge pclk) disable iff (!presetn)
    (enabled_ff && watchdog_refresh && count > NO_REFRESH_CNT)
      |=> (count == $past(reload_ff))
  ) else $error("refresh did not reload the counter");

  AST_READ_COUNT: assert property ( // R12
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && sel == SEL_MIDDLE)
      |=> (prdata == {24'h00_0000, $past(count[MIDDLE_LSB +: BYTE_W])})
  ) else $error("reload byte read did not return live count");

  AST_WDT_RESET_FLAG: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    wdt_reset_req |=>
      (status_ff[FLAG_WDT_RESET] && irq == mask_ff[FLAG_WDT_RESET])
  ) else $error("watchdog reset flag not set");

  AST_REFRESH_ENABLES: assert property ( // R8
    @(posedge pclk) disable iff (!presetn)
    (strap_done_ff && watchdog_refresh) |=> enabled_ff
  ) else $error("refresh did not enable the watchdog");

  AST_STOP_DISABLES: assert property ( // R16
    @(posedge pclk) disable iff (!presetn)
    (strap_done_ff && ao_ff != AO_RUN_FROM_RESET && stop_mode_recovery
      && !watchdog_refresh) |=> !enabled_ff
  ) else $error("stop recovery did not disable the watchdog");

  AST_RESET_PULSE: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    wdt_reset_req |=> !wdt_reset_req
  ) else $error("reset request lasted more than one cycle");

  AST_STATUS_CLEAR: assert property ( // R2
    @(posedge pclk) disable iff (!presetn)
    (wr && sel == SEL_STATUS && wbyte[FLAG_TIMEOUT_IRQ]
      && !flag_set[FLAG_TIMEOUT_IRQ]) |=> !status_ff[FLAG_TIMEOUT_IRQ]
  ) else $error("written one did not clear the interrupt flag");

  AST_STRAP_HELD: assert property ( // R13
    @(posedge pclk) disable iff (!presetn)
    strap_done_ff |=> ($stable(ao_ff) && $stable(resp_ff))
  ) else $error("option straps changed after they were latched");
endmodule // watchdog_timer_24bit

/* File: tb_top.sv */
// self-checking testbench of the watchdog timer over apb
`timescale 1ns/1ps
module tb_top
  import wdt_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic rc_osc_clk, watchdog_refresh, stop_mode_recovery;
  logic always_on_option, timeout_response_select, wdt_reset_req, irq;
  logic [32:0] expq[$];
  logic [7:0] u, m, l;
  int fails = 0;
  int comparisons = 0;
  int rst_pulses = 0;
  int p;

  watchdog_timer_24bit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_osc_clk(rc_osc_clk), .watchdog_refresh(watchdog_refresh),
    .stop_mode_recovery(stop_mode_recovery),
    .always_on_option(always_on_option),
    .timeout_response_select(timeout_response_select),
    .wdt_reset_req(wdt_reset_req), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // read results are compared when the access phase completes
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (expq.size() == 0) begin
        fails++;
      end else begin
        check({pslverr, prdata}, expq.pop_front());
      end
    end
    if (wdt_reset_req === 1'b1) begin
      rst_pulses++;
    end
  end

  task automatic apb(input logic wr, input logic [11:0] idx,
                     input logic [31:0] wd, input logic [32:0] exp);
    int n;
    n = 0;
    if (!wr) begin
      expq.push_back(exp);
    end
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 50) begin
      fails++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0000_0000, {1'b0, e});
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h00_0000, d}, 33'h0_0000_0000);
  endtask

  task automatic rdcnt(input logic [23:0] c);
    rd(IDX_RELOAD_UPPER, {24'h00_0000, c[23:16]});
    rd(IDX_RELOAD_MIDDLE, {24'h00_0000, c[15:8]});
    rd(IDX_RELOAD_LOW, {24'h00_0000, c[7:0]});
  endtask

  // slow oscillator: wide phases so the synchroniser sees every edge
  task automatic tick(input int k);
    repeat (k) begin
      rc_osc_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      rc_osc_clk <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask

  task automatic pulse(input logic stop);
    if (stop) stop_mode_recovery <= 1'b1;
    else watchdog_refresh <= 1'b1;
    @(posedge pclk);
    stop_mode_recovery <= 1'b0;
    watchdog_refresh <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic do_reset(input logic ao, input logic resp);
    presetn <= 1'b0;
    always_on_option <= ao;
    timeout_response_select <= resp;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // straps latch on edge 1, an always-on dog is enabled on edge 2
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, rc_osc_clk} = 4'h0;
    {watchdog_refresh, stop_mode_recovery} = 2'h0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    always_on_option = 1'b1;
    timeout_response_select = 1'b0;
    void'($urandom(32'h51c4_84f5));
    do_reset(1'b1, 1'b0);
    rdcnt(24'h00_0400);
    rd(IDX_MASK, 32'h0000_0001);
    rd(IDX_OPTIONS, 32'h0000_0002);
    tick(2);
    rdcnt(24'h00_0400);
    u = 8'($urandom_range(255, 1));
    m = 8'($urandom());
    l = 8'($urandom());
    wr(IDX_RELOAD_UPPER, u);
    wr(IDX_RELOAD_MIDDLE, m);
    wr(IDX_RELOAD_LOW, l);
    rdcnt(24'h00_0400);
    pulse(1'b0);
    rdcnt({u, m, l});
    rd(IDX_OPTIONS, 32'h0000_0003);
    wr(IDX_RELOAD_UPPER, 8'h00);
    wr(IDX_RELOAD_MIDDLE, 8'h00);
    wr(IDX_RELOAD_LOW, 8'h05);
    pulse(1'b0);
    rdcnt(24'h00_0005);
    tick(3);
    rdcnt(24'h00_0002);
    pulse(1'b0);
    rdcnt(24'h00_0002);
    tick(2);
    check({32'h0, irq}, 33'h1);
    check(33'(rst_pulses), 33'h0);
    rdcnt(24'h00_0005);
    rd(IDX_STATUS, 32'h0000_0001);
    wr(IDX_MASK, 8'h00);
    check({32'h0, irq}, 33'h0);
    wr(IDX_MASK, 8'h01);
    check({32'h0, irq}, 33'h1);
    wr(IDX_STATUS, 8'h01);
    check({32'h0, irq}, 33'h0);
    rd(IDX_STATUS, 32'h0000_0000);
    apb(1'b0, 12'h0ff7, 32'h0, {1'b1, 32'h0000_0000});
    pulse(1'b1);
    rd(IDX_OPTIONS, 32'h0000_0002);
    // second run: always on, system reset response
    do_reset(1'b0, 1'b1);
    rd(IDX_OPTIONS, 32'h0000_0005);
    wr(IDX_RELOAD_MIDDLE, 8'h00);
    wr(IDX_RELOAD_LOW, 8'h04);
    pulse(1'b0);
    rdcnt(24'h00_0004);
    pulse(1'b1);
    rd(IDX_OPTIONS, 32'h0000_0005);
    p = rst_pulses;
    tick(3);
    check(33'(rst_pulses), 33'(p));
    tick(1);
    check(33'(rst_pulses), 33'(p + 1));
    check({32'h0, irq}, 33'h0);
    rd(IDX_STATUS, 32'h0000_0002);
    rdcnt(24'h00_0004);
    end_sim();
  end
endmodule // tb_top
